/* File: hw/port_p_pkg.sv */
// Constants shared by the port P data and pin arbitration block.
// Assumes a 32-bit APB bus on pclk; byte addresses are full 16-bit offsets.
package port_p_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned PINS     = 6;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned EVENTS   = 7;
  localparam int unsigned SYNC_LEN = 2;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PIN_DATA_OFS   = 16'h0258;
  localparam logic [ADDR_W-1:0] DIRECTION_OFS  = 16'h0260;
  localparam logic [ADDR_W-1:0] FUNC_CTRL_OFS  = 16'h0264;
  localparam logic [ADDR_W-1:0] PIN_INT_EN_OFS = 16'h0268;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 16'h026C;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS  = 16'h0270;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 16'h0274;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [PINS-1:0]   PIN_DATA_RST  = 6'h00;
  localparam logic [PINS-1:0]   DIRECTION_RST = 6'h00;
  localparam logic [REG_W-1:0]  FUNC_CTRL_RST = 8'h00;
  localparam logic [PINS-1:0]   INT_EN_RST    = 6'h00;
  localparam logic [EVENTS-1:0] STATUS_RST    = 7'h00;
  localparam logic [DATA_W-1:0] RDATA_RST     = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Function control fields
  // ----------------------------------------------------------------------
  localparam int unsigned FC_EXT_IRQ   = 0;  // External interrupt pin enable
  localparam int unsigned FC_SUPPLY    = 1;  // Bit 2 used as switched supply
  localparam int unsigned FC_SER_LO    = 2;  // Pulse channels 4,5 to serial port
  localparam int unsigned FC_DRV_LO    = 4;  // Pins 1,3,4,5 taken by a driver

  // ----------------------------------------------------------------------
  // Pin and event positions
  // ----------------------------------------------------------------------
  localparam int unsigned PIN_NMI      = 1;
  localparam int unsigned PIN_SUPPLY   = 2;
  localparam int unsigned PIN_TRIG0    = 4;
  localparam int unsigned PIN_IRQ      = 5;
  localparam int unsigned EV_OVERCUR   = 6;

endpackage : port_p_pkg

/* File: hw/level_sync.sv */
// Two-stage synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; no bus coherence is promised.
`timescale 1ns/100ps

module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             pclk,    // System clock
  input  wire logic             presetn, // Async reset, active low
  input  wire logic [WIDTH-1:0] async_in, // Level from another domain
  output logic      [WIDTH-1:0] sync_out  // Level on pclk
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : level_sync

/* File: hw/port_p_pins.sv */
// Port P data register, APB slave and per-pin function arbitration.
// Assumes pulse-width and mask inputs on pclk; pin and over-current levels async.
//
// Operation
// - The pin data register sits at 0x0258, resets to zero and reads bits 7:6 as zero.
// - The pin data register may be read and written at any time.
// - A data read returns the stored bit where direction is 1, else the synced pin.
// - A general-purpose output pin with no alternative owner drives its stored bit.
// - An enabled external interrupt function forces pin 5 to input.
// - On pin 5 the external interrupt beats both pulse-width and general-purpose use.
// - An enabled pulse-width channel overrides general-purpose control of its pin.
// - Enabled pin interrupts fire whether the pin is an input or an output.
// - Pins 5 and 4 feed the external trigger inputs without touching pin state.
// - In supply mode pin 2 drives its stored bit and may raise an over-current interrupt.
// - Pulse-width on pins 5 and 4 is offered only when not routed to the serial port.
// - Pulse-width on pins 5,4,3,1 is offered only when no driver function holds the pin.
// - Pin 1 turns input on the first mask clear and stays input after the mask is set.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps

module port_p_pins
  import port_p_pkg::*;
(
  input  wire logic                           pclk,       // System clock
  input  wire logic                           presetn,    // Async reset, active low
  input  wire logic                           psel,       // APB select
  input  wire logic                           penable,    // APB access phase
  input  wire logic                           pwrite,     // APB write
  input  wire logic [port_p_pkg::ADDR_W-1:0]  paddr,      // APB byte address
  input  wire logic [port_p_pkg::DATA_W-1:0]  pwdata,     // APB write data
  output logic      [port_p_pkg::DATA_W-1:0]  prdata,     // APB read data
  output logic                                pready,     // APB ready
  output logic                                pslverr,    // APB error
  input  wire logic [port_p_pkg::PINS-1:0]    pin_in,     // Pad input levels
  output logic      [port_p_pkg::PINS-1:0]    pin_out,    // Pad output levels
  output logic      [port_p_pkg::PINS-1:0]    pin_oe_n,   // Pad drive, low drives
  input  wire logic [port_p_pkg::PINS-1:0]    pwm_out,    // Pulse-width channel outputs
  input  wire logic [port_p_pkg::PINS-1:0]    pwm_enable, // Pulse-width channel enables
  input  wire logic                           nmi_mask,   // Nonmaskable mask bit
  input  wire logic                           over_current, // Supply over-current level
  output logic      [1:0]                     external_trigger_input, // Trigger levels
  output logic                                ext_irq_level, // External interrupt level
  output logic                                nonmaskable_interrupt_input, // Pin 1 level
  output logic                                irq         // Interrupt, active high
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic [DATA_W-1:0] zext6(input logic [PINS-1:0] v);
    zext6 = {{(DATA_W-PINS){1'b0}}, v};
  endfunction : zext6

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [PINS-1:0]   port_p_pin_data;
  logic [PINS-1:0]   port_p_direction;
  logic [REG_W-1:0]  func_ctrl;
  logic [PINS-1:0]   pin_int_en;
  logic [EVENTS-1:0] irq_status;
  logic [EVENTS-1:0] irq_enable;
  logic [PINS-1:0]   pin_sync;
  logic [PINS-1:0]   pin_prev;
  logic              overcur_sync;
  logic              overcur_prev;
  logic              nmi_latched;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  level_sync #(
    .WIDTH (PINS + 1)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({over_current, pin_in}),
    .sync_out ({overcur_sync, pin_sync})
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire access_phase = psel && penable;
  wire first_access = access_phase && !pready;
  wire commit       = access_phase && pready;
  wire wr_commit    = commit && pwrite;
  wire hit_data     = hit(paddr, PIN_DATA_OFS);
  wire hit_dir      = hit(paddr, DIRECTION_OFS);
  wire hit_ctrl     = hit(paddr, FUNC_CTRL_OFS);
  wire hit_inten    = hit(paddr, PIN_INT_EN_OFS);
  wire hit_status   = hit(paddr, IRQ_STATUS_OFS);
  wire hit_clear    = hit(paddr, IRQ_CLEAR_OFS);
  wire hit_enable   = hit(paddr, IRQ_ENABLE_OFS);
  wire mapped       = hit_data || hit_dir || hit_ctrl || hit_inten || hit_status
                      || hit_clear || hit_enable;

  // Read value of the data register depends on each direction bit
  wire [PINS-1:0] data_view = (port_p_direction & port_p_pin_data)
                              | (~port_p_direction & pin_sync);

  logic [DATA_W-1:0] read_mux;
  always_comb begin
    if (hit_data) begin
      read_mux = zext6(data_view);
    end else if (hit_dir) begin
      read_mux = zext6(port_p_direction);
    end else if (hit_ctrl) begin
      read_mux = {{(DATA_W-REG_W){1'b0}}, func_ctrl};
    end else if (hit_inten) begin
      read_mux = zext6(pin_int_en);
    end else if (hit_status) begin
      read_mux = {{(DATA_W-EVENTS){1'b0}}, irq_status};
    end else if (hit_enable) begin
      read_mux = {{(DATA_W-EVENTS){1'b0}}, irq_enable};
    end else begin
      read_mux = RDATA_RST;
    end
  end

  // ----------------------------------------------------------------------
  // APB answer: one wait state, then ready for a single cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RDATA_RST;
    end else begin
      pready  <= first_access;
      pslverr <= first_access && !mapped;
      if (first_access && !pwrite) begin
        prdata <= read_mux;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_p_pin_data  <= PIN_DATA_RST;
      port_p_direction <= DIRECTION_RST;
      func_ctrl        <= FUNC_CTRL_RST;
      pin_int_en       <= INT_EN_RST;
      irq_enable       <= STATUS_RST;
    end else if (wr_commit) begin
      if (hit_data)   port_p_pin_data  <= pwdata[PINS-1:0];
      if (hit_dir)    port_p_direction <= pwdata[PINS-1:0];
      if (hit_ctrl)   func_ctrl        <= pwdata[REG_W-1:0];
      if (hit_inten)  pin_int_en       <= pwdata[PINS-1:0];
      if (hit_enable) irq_enable       <= pwdata[EVENTS-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Pin arbitration
  // ----------------------------------------------------------------------
  wire ext_irq_on = func_ctrl[FC_EXT_IRQ];
  wire supply_on  = func_ctrl[FC_SUPPLY];
  wire [1:0] ser_route = func_ctrl[FC_SER_LO +: 2];
  wire [3:0] drv_taken = func_ctrl[FC_DRV_LO +: 4];

  // Serial routing only affects channels 4 and 5
  wire [PINS-1:0] ser_block = {ser_route, 4'h0};
  // Driver functions hold pins 5,4,3,1
  wire [PINS-1:0] drv_block = {drv_taken[3:1], 1'b0, drv_taken[0], 1'b0};
  wire [PINS-1:0] pwm_own   = pwm_enable & ~ser_block & ~drv_block;

  // Input forcing: external interrupt on 5, nonmaskable input on 1
  wire [PINS-1:0] force_in  = {ext_irq_on, 3'h0, nmi_latched, 1'b0};

  logic [PINS-1:0] next_pin_out;
  logic [PINS-1:0] next_pin_oe_n;
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (force_in[i]) begin
        next_pin_out[i]  = 1'b0;
        next_pin_oe_n[i] = 1'b1;
      end else if (i == PIN_SUPPLY && supply_on) begin
        next_pin_out[i]  = port_p_pin_data[i];
        next_pin_oe_n[i] = 1'b0;
      end else if (pwm_own[i]) begin
        next_pin_out[i]  = pwm_out[i];
        next_pin_oe_n[i] = 1'b0;
      end else begin
        next_pin_out[i]  = port_p_pin_data[i];
        next_pin_oe_n[i] = !port_p_direction[i];
      end
    end
  end

  // Once the mask has been cleared the pin stays an input until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_latched <= 1'b0;
    end else if (!nmi_mask) begin
      nmi_latched <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out                     <= PIN_DATA_RST;
      pin_oe_n                    <= '1;
      external_trigger_input      <= 2'h0;
      ext_irq_level               <= 1'b0;
      nonmaskable_interrupt_input <= 1'b0;
    end else begin
      pin_out                     <= next_pin_out;
      pin_oe_n                    <= next_pin_oe_n;
      external_trigger_input      <= pin_sync[PIN_TRIG0 +: 2];
      ext_irq_level               <= pin_sync[PIN_IRQ] && ext_irq_on;
      nonmaskable_interrupt_input <= pin_sync[PIN_NMI] && nmi_latched;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  // Pin edges are seen from the synced pad, so output pins fire as well
  wire [PINS-1:0]   pin_edge  = (pin_sync ^ pin_prev) & pin_int_en;
  wire              oc_event  = overcur_sync && !overcur_prev && supply_on;
  wire [EVENTS-1:0] ev_set    = {oc_event, pin_edge};
  wire [EVENTS-1:0] ev_clear  = (wr_commit && hit_clear) ? pwdata[EVENTS-1:0] : STATUS_RST;
  // Set wins over a clear in the same cycle
  wire [EVENTS-1:0] next_status = (irq_status & ~ev_clear) | ev_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev     <= PIN_DATA_RST;
      overcur_prev <= 1'b0;
      irq_status   <= STATUS_RST;
      irq          <= 1'b0;
    end else begin
      pin_prev     <= pin_sync;
      overcur_prev <= overcur_sync;
      irq_status   <= next_status;
      irq          <= |(next_status & irq_enable);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence data_read_s;
    first_access && !pwrite && hit_data;
  endsequence

  sequence gpio_out_s(int unsigned i);
    !force_in[i] && !pwm_own[i] && port_p_direction[i] && !(i == PIN_SUPPLY && supply_on);
  endsequence

  AST_READ_UPPER_ZERO: assert property (data_read_s |=> prdata[7:6] == 2'b00 && pready)
    else $error("Data register upper bits not zero");

  AST_READ_SOURCE: assert property (data_read_s |=> prdata[PINS-1:0] == $past(data_view))
    else $error("Data read source wrong");

  AST_WRITE_STORES: assert property (wr_commit && hit_data
      |=> port_p_pin_data == $past(pwdata[PINS-1:0]))
    else $error("Data write not stored");

  AST_GPIO_DRIVE: assert property (gpio_out_s(0) |=> !pin_oe_n[0] && pin_out[0] == $past(port_p_pin_data[0]))
    else $error("General output pin 0 not driven");

  AST_IRQ_FORCES_IN: assert property (ext_irq_on |=> pin_oe_n[PIN_IRQ])
    else $error("Pin 5 not input under external interrupt");

  AST_IRQ_BEATS_PWM: assert property (ext_irq_on && pwm_enable[PIN_IRQ] && port_p_direction[PIN_IRQ]
      |=> pin_oe_n[PIN_IRQ])
    else $error("Pin 5 driven despite external interrupt");

  AST_PWM_DRIVE: assert property (pwm_own[3] |=> !pin_oe_n[3] && pin_out[3] == $past(pwm_out[3]))
    else $error("Pulse channel 3 not on its pin");

  AST_PIN_EVENT: assert property (pin_edge[0] |=> irq_status[0])
    else $error("Pin edge did not set status");

  AST_TRIGGER: assert property (##1 external_trigger_input == $past(pin_sync[PIN_TRIG0 +: 2]))
    else $error("Trigger input not following pin");

  AST_SUPPLY: assert property (supply_on && !ext_irq_on ##0 !nmi_latched
      |=> !pin_oe_n[PIN_SUPPLY] && pin_out[PIN_SUPPLY] == $past(port_p_pin_data[PIN_SUPPLY]))
    else $error("Supply pin not driven");

  AST_SERIAL_BLOCK: assert property (ser_route[0] && !port_p_direction[PIN_TRIG0]
      && !ext_irq_on |=> pin_oe_n[PIN_TRIG0])
    else $error("Pulse on pin 4 despite serial routing");

  AST_DRIVER_BLOCK: assert property (drv_taken[1] && !port_p_direction[3] |=> pin_oe_n[3])
    else $error("Pulse on pin 3 despite driver function");

  // Latch settles one edge after the mask clear, the pad register one edge later
  AST_NMI_HOLD: assert property (!nmi_mask |-> ##2 pin_oe_n[PIN_NMI] [*3])
    else $error("Pin 1 left input state after mask clear");

endmodule : port_p_pins

/* File: tb/port_p_far_side.sv */
// Far side of port P: pads with external sources and a supply load.
// Assumes the bench sets external levels; the device wins where it drives.
`timescale 1ns/100ps

module port_p_far_side
  import port_p_pkg::*;
(
  input  wire logic [port_p_pkg::PINS-1:0] pin_out,     // Device pad value
  input  wire logic [port_p_pkg::PINS-1:0] pin_oe_n,    // Device drive, low drives
  input  wire logic [port_p_pkg::PINS-1:0] ext_level,   // External source level
  input  wire logic                        load_short,  // Short on the supply pin
  output logic      [port_p_pkg::PINS-1:0] pin_in,      // Resolved pad level
  output logic                             over_current // Protection trip level
);
  // --------------------------------------------------------------------
  // Pad resolution
  // --------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      pin_in[i] = (pin_oe_n[i] == 1'b0) ? pin_out[i] : ext_level[i];
    end
  end

  // Trips only while the supply pin is driven high into a short
  assign over_current = load_short & pin_in[PIN_SUPPLY] & ~pin_oe_n[PIN_SUPPLY];
endmodule : port_p_far_side

/* File: tb/port_p_pins_tb.sv */
// Self-checking bench for the port P data register and pin arbitration.
// Assumes the far-side pad model and an APB master written as tasks here.
`timescale 1ns/100ps

module port_p_pins_tb;
  import port_p_pkg::*;

  // --------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic              nmi_mask, over_current, ext_irq_level, irq, load_short;
  logic              nonmaskable_interrupt_input;
  logic [1:0]        external_trigger_input;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [PINS-1:0]   pin_in, pin_out, pin_oe_n, pwm_out, pwm_enable, ext_level;
  int                err_total = 0;
  int                samples_checked = 0;

  port_p_pins dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pin_in, .pin_out, .pin_oe_n, .pwm_out, .pwm_enable, .nmi_mask, .over_current,
    .external_trigger_input, .ext_irq_level, .nonmaskable_interrupt_input, .irq
  );
  port_p_far_side far (
    .pin_out, .pin_oe_n, .ext_level, .load_short, .pin_in, .over_current
  );

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Called just after a rising edge; returns one edge after release
  // Waits for ready without a limit of its own; the watchdog ends a hang
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    logic              e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] q;
    logic              e;
    apb(1'b0, a, '0, q, e);
    chk({e, q}, {1'b0, exp}, "register read");
  endtask : rd_chk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_gpio();
    logic [DATA_W-1:0] q;
    logic              e;
    chk(pin_oe_n, 33'h3F, "pads released at reset");
    rd_chk(PIN_DATA_OFS, 32'h0);
    wr(DIRECTION_OFS, 32'h3F);
    wr(PIN_DATA_OFS, 32'hFF);
    rd_chk(PIN_DATA_OFS, 32'h3F);
    chk(pin_out, 33'h3F, "gpio level");
    chk(pin_oe_n, 33'h0, "gpio drive");
    wr(PIN_DATA_OFS, 32'h15);
    rd_chk(PIN_DATA_OFS, 32'h15);
    wr(DIRECTION_OFS, 32'h07);
    ext_level <= 6'h2A;
    wt(5);
    rd_chk(PIN_DATA_OFS, 32'h2D);
    apb(1'b0, 16'h0300, '0, q, e);
    chk({e, q}, 33'h1_0000_0000, "unmapped read");
  endtask : t_gpio

  task automatic t_pwm();
    wr(DIRECTION_OFS, 32'h0);
    pwm_out <= 6'h2A;
    pwm_enable <= 6'h3E;
    wt(3);
    chk(pin_oe_n, 33'h01, "pwm drive");
    chk(pin_out[5:1], 33'h15, "pwm level");
    wr(FUNC_CTRL_OFS, 32'h0C);
    wt(2);
    chk(pin_oe_n, 33'h31, "serial routed");
    wr(FUNC_CTRL_OFS, 32'hF0);
    wt(2);
    chk(pin_oe_n, 33'h3B, "driver taken");
  endtask : t_pwm

  task automatic t_ext_irq();
    wr(FUNC_CTRL_OFS, 32'h0);
    wr(DIRECTION_OFS, 32'h20);
    ext_level <= 6'h20;
    wr(FUNC_CTRL_OFS, 32'h01);
    wt(5);
    chk(pin_oe_n[5], 33'h1, "irq pin forced input");
    chk(ext_irq_level, 33'h1, "irq level high");
    ext_level <= 6'h00;
    wt(5);
    chk(ext_irq_level, 33'h0, "irq level low");
    wr(FUNC_CTRL_OFS, 32'h0);
    wt(2);
    chk({pin_oe_n[5], pin_out[5]}, 33'h1, "pwm back on pin 5");
  endtask : t_ext_irq

  task automatic t_trig();
    pwm_enable <= 6'h00;
    wr(DIRECTION_OFS, 32'h30);
    wr(PIN_DATA_OFS, 32'h10);
    wt(5);
    chk(external_trigger_input, 33'h1, "trigger from pin 4");
    chk(pin_oe_n[5:4], 33'h0, "trigger pins still outputs");
    wr(PIN_DATA_OFS, 32'h20);
    wt(5);
    chk(external_trigger_input, 33'h2, "trigger from pin 5");
  endtask : t_trig

  task automatic t_supply();
    wr(FUNC_CTRL_OFS, 32'h02);
    wr(DIRECTION_OFS, 32'h04);
    wr(PIN_DATA_OFS, 32'h04);
    pwm_enable <= 6'h04;
    wt(5);
    wr(IRQ_CLEAR_OFS, 32'h7F);
    chk({pin_oe_n[2], pin_out[2]}, 33'h1, "supply driven");
    load_short <= 1'b1;
    wt(5);
    rd_chk(IRQ_STATUS_OFS, 32'h40);
    chk(irq, 33'h0, "over-current not enabled");
    wr(IRQ_ENABLE_OFS, 32'h40);
    wt(2);
    chk(irq, 33'h1, "over-current irq");
    wr(IRQ_CLEAR_OFS, 32'h40);
    wt(2);
    chk(irq, 33'h0, "over-current cleared");
    rd_chk(IRQ_CLEAR_OFS, 32'h0);
    load_short <= 1'b0;
    pwm_enable <= 6'h00;
    wr(FUNC_CTRL_OFS, 32'h0);
  endtask : t_supply

  task automatic t_pin_irq();
    wr(PIN_INT_EN_OFS, 32'h03);
    wr(DIRECTION_OFS, 32'h01);
    wr(PIN_DATA_OFS, 32'h00);
    wt(5);
    wr(IRQ_CLEAR_OFS, 32'h7F);
    wr(IRQ_ENABLE_OFS, 32'h03);
    wr(PIN_DATA_OFS, 32'h01);
    wt(5);
    rd_chk(IRQ_STATUS_OFS, 32'h01);
    chk(irq, 33'h1, "output pin irq");
    wr(IRQ_ENABLE_OFS, 32'h02);
    wt(2);
    chk(irq, 33'h0, "irq masked");
    ext_level <= 6'h02;
    wt(5);
    rd_chk(IRQ_STATUS_OFS, 32'h03);
    chk(irq, 33'h1, "input pin irq");
    wr(IRQ_CLEAR_OFS, 32'h03);
    wt(2);
    chk(irq, 33'h0, "irq cleared");
  endtask : t_pin_irq

  task automatic t_nmi();
    wr(DIRECTION_OFS, 32'h02);
    wr(PIN_DATA_OFS, 32'h02);
    wt(2);
    chk(pin_oe_n[1], 33'h0, "pin 1 output before unmask");
    nmi_mask <= 1'b0;
    wt(2);
    nmi_mask <= 1'b1;
    ext_level <= 6'h00;
    wt(5);
    chk({pin_oe_n[1], nonmaskable_interrupt_input}, 33'h2, "pin 1 held input");
    ext_level <= 6'h02;
    wt(5);
    chk(nonmaskable_interrupt_input, 33'h1, "nmi level follows pad");
  endtask : t_nmi

  initial begin
    {psel, penable, pwrite, presetn, load_short} = '0;
    nmi_mask = 1'b1;
    paddr = '0;
    pwdata = '0;
    pwm_out = '0;
    pwm_enable = '0;
    ext_level = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_gpio();
    t_pwm();
    t_ext_irq();
    t_trig();
    t_supply();
    t_pin_irq();
    t_nmi();
    give_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : port_p_pins_tb
